/* lpm_pkg.sv */
// Constants for the low-power mode sequencer: register map, field positions,
// reset values and timing counts.
// Assumes a 25 MHz core clock and a 32-bit Avalon-MM register bus.
package lpm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [3:0] POWER_CONTROL_REGISTER_OFF = 4'h0;
	localparam logic [3:0] CFG_OFF = 4'h4;
	localparam logic [3:0] STAT_OFF = 4'h8;

	////////////////////////////////////////////////////////////////////////////
	// Power control register fields
	localparam int IDL_BIT = 0;
	localparam int PD_BIT = 1;
	localparam int GF0_BIT = 2;
	localparam int GF1_BIT = 3;
	localparam logic [1:0] GF_RESET = 2'h0;

	// Configuration register fields
	localparam int WAKE0_EN_BIT = 0;
	localparam int WAKE1_EN_BIT = 1;
	localparam int EXT_CODE_BIT = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;

	// Status register fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_OSC_BIT = 3;
	localparam int STAT_SRC_LSB = 4;
	localparam int STAT_LINE_LSB = 6;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_FREQ_MHZ = 25;
	localparam int OSC_STABLE_TIME_US = 2;
	localparam int OSC_STABLE_CYCLES = OSC_STABLE_TIME_US * CLK_FREQ_MHZ;
	localparam int RESET_TAKEOVER_CYCLES = 4;

	// Port pin levels
	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 5;
	localparam logic [PORT_W-1:0] PORT_HIGH = 8'hff;

endpackage : lpm_pkg

/* lpm_sync2.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are quasi-static levels; no pulse stretching.
`timescale 1ns/1ns
module lpm_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule : lpm_sync2

/* low_power_mode_sequencer.sv */
// Idle and power-down sequencer: clock gating, wake-up by external lines or
// reset pin, and port/strobe pin conditions in each special mode.
// Assumes clk is the oscillator reference and that the core obeys the gates.
//
// Functional notes
// - Reset pin high clears idle request at once, restoring processor clock.
// - After reset exit from idle, brief execution precedes the internal reset.
// - During that brief execution RAM is blocked, ports stay writable.
// - Power-down stops oscillator, holds clocks; state and RAM kept.
// - Power-down starts right after the request write; nothing runs after.
// - Only the two external wake lines or the reset pin can end power-down.
// - Enabled external wake clears power-down bit and restarts oscillator.
// - Execution resumes only after the wake line is released.
// - Interrupt wake leaves registers and RAM unchanged.
// - Reset pin clears power-down bit asynchronously, restarts clocks, brief run.
// - Reset wake reinitialises registers but keeps RAM.
// - Pin levels: reset, idle and power-down each force defined states.
// - Power-down wins over idle; no idle after leaving power-down.
// - Idle freezes processor clock; peripherals keep running.
// - Both request bits reset to zero and clear on interrupt or reset.
`timescale 1ns/1ns
module low_power_mode_sequencer #(
	parameter int unsigned OSC_CYCLES = lpm_pkg::OSC_STABLE_CYCLES
) (
	// Clock and resets
	input wire logic clk,
	input wire logic reset,
	input wire logic rst_pin,
	// External wake lines
	input wire logic ext_wake_irq0_n,
	input wire logic ext_wake_irq1_n,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core side
	input wire logic core_irq_taken,
	input wire logic [lpm_pkg::PORT_W*lpm_pkg::NUM_PORTS-1:0] port_data_in,
	input wire logic core_port0_oe,
	input wire logic core_ale,
	input wire logic core_fetch_strobe_n,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_enable,
	output logic core_reset,
	output logic ram_block,
	// Pins
	output logic [lpm_pkg::PORT_W*lpm_pkg::NUM_PORTS-1:0] port_out,
	output logic port0_oe,
	output logic ale,
	output logic program_fetch_strobe_n
);
	import lpm_pkg::*;

	localparam int PW = PORT_W * NUM_PORTS;

	typedef enum logic [2:0] {
		st_run,
		st_idle,
		st_pd,
		st_osc_wait,
		st_wait_release,
		st_reset_run,
		st_reset_hold
	} mode_e;

	function automatic logic [2:0] mode_code(input mode_e m);
		case (m)
			st_run: mode_code = 3'h0;
			st_idle: mode_code = 3'h1;
			st_pd: mode_code = 3'h2;
			st_osc_wait: mode_code = 3'h3;
			st_wait_release: mode_code = 3'h4;
			st_reset_run: mode_code = 3'h5;
			st_reset_hold: mode_code = 3'h6;
			default: mode_code = 3'h7;
		endcase
	endfunction : mode_code

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [2:0] pins_s;
	logic rst_s;
	logic wake0_s;
	logic wake1_s;

	lpm_sync2 #(.W(3), .RESET_VAL(3'h6)) u_sync (
		.clk(clk),
		.reset(reset),
		.d({ext_wake_irq1_n, ext_wake_irq0_n, rst_pin}),
		.q(pins_s)
	);

	assign rst_s = pins_s[0];
	assign wake0_s = ~pins_s[1];
	assign wake1_s = ~pins_s[2];

	////////////////////////////////////////////////////////////////////////////
	// State
	mode_e state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic pd_q, pd_d;
	logic idl_q, idl_d;
	logic [1:0] gf_q, gf_d;
	logic [2:0] cfg_q, cfg_d;
	logic [1:0] src_q, src_d;
	logic cpu_clk_en_q, cpu_clk_en_d;
	logic periph_clk_en_q, periph_clk_en_d;
	logic osc_enable_q, osc_enable_d;
	logic core_reset_q, core_reset_d;
	logic ram_block_q, ram_block_d;
	logic [PW-1:0] port_out_q, port_out_d;
	logic port0_oe_q, port0_oe_d;
	logic ale_q, ale_d;
	logic fetch_n_q, fetch_n_d;
	logic waitrequest_q, waitrequest_d;
	logic [31:0] readdata_q, readdata_d;

	logic wake_req;
	logic power_control_register_wr;
	logic cfg_wr;
	logic ext_code;

	// Only the two external lines, each gated by its enable
	assign wake_req = (cfg_q[WAKE0_EN_BIT] & wake0_s) | (cfg_q[WAKE1_EN_BIT] & wake1_s);
	assign ext_code = cfg_q[EXT_CODE_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then the access completes
	always_comb
	begin
		waitrequest_d = 1'b1;
		readdata_d = readdata_q;
		if ((avs_read || avs_write) && waitrequest_q && !reset)
		begin
			waitrequest_d = 1'b0;
			readdata_d = 32'h0;
			case (avs_address)
				POWER_CONTROL_REGISTER_OFF: readdata_d = {28'h0, gf_q, pd_q, idl_q};
				CFG_OFF: readdata_d = {29'h0, cfg_q};
				STAT_OFF: readdata_d = {24'h0, wake1_s, wake0_s, src_q, osc_enable_q, mode_code(state_q)};
				default: readdata_d = 32'h0;
			endcase
		end
	end

	assign power_control_register_wr = avs_write && !waitrequest_q && avs_byteenable[0] && avs_address == POWER_CONTROL_REGISTER_OFF;
	assign cfg_wr = avs_write && !waitrequest_q && avs_byteenable[0] && avs_address == CFG_OFF;

	always_ff @(posedge clk)
	begin
		waitrequest_q <= waitrequest_d;
		readdata_q <= readdata_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode sequencing
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		pd_d = pd_q;
		idl_d = idl_q;
		gf_d = gf_q;
		cfg_d = cfg_q;
		src_d = src_q;
		if (power_control_register_wr)
			gf_d = avs_writedata[GF1_BIT:GF0_BIT];
		if (cfg_wr)
			cfg_d = avs_writedata[2:0];
		case (state_q)
			st_run:
			begin
				if (rst_s)
					state_d = st_reset_hold;
				else if (power_control_register_wr && avs_writedata[PD_BIT])
				begin
					// Power-down wins; idle is dropped so it cannot follow
					pd_d = 1'b1;
					idl_d = 1'b0;
					state_d = st_pd;
				end
				else if (power_control_register_wr && avs_writedata[IDL_BIT])
				begin
					idl_d = 1'b1;
					state_d = st_idle;
				end
			end
			st_idle:
			begin
				if (rst_s)
				begin
					cnt_d = 16'h0;
					state_d = st_reset_run;
				end
				else if (core_irq_taken)
				begin
					idl_d = 1'b0;
					state_d = st_run;
				end
			end
			st_pd:
			begin
				if (rst_s)
				begin
					cnt_d = 16'h0;
					state_d = st_reset_run;
				end
				else if (wake_req)
				begin
					pd_d = 1'b0;
					src_d = {wake1_s, wake0_s};
					cnt_d = 16'h0;
					// No core reset on this path: registers and RAM untouched
					state_d = st_osc_wait;
				end
			end
			st_osc_wait:
			begin
				cnt_d = cnt_q + 16'h1;
				if (rst_s)
				begin
					cnt_d = 16'h0;
					state_d = st_reset_run;
				end
				else if (cnt_q >= 16'(OSC_CYCLES - 1))
					state_d = st_wait_release;
			end
			st_wait_release:
			begin
				// Resume only once every enabled line is released
				if (rst_s)
				begin
					cnt_d = 16'h0;
					state_d = st_reset_run;
				end
				else if (!wake_req)
					state_d = st_run;
			end
			st_reset_run:
			begin
				cnt_d = cnt_q + 16'h1;
				if (cnt_q >= 16'(RESET_TAKEOVER_CYCLES - 1))
					state_d = st_reset_hold;
			end
			st_reset_hold:
			begin
				// Registers reinitialised; RAM is not touched here
				gf_d = GF_RESET;
				cfg_d = CFG_RESET;
				idl_d = 1'b0;
				pd_d = 1'b0;
				if (!rst_s)
					state_d = st_run;
			end
			default: state_d = st_run;
		endcase
		if (reset)
		begin
			state_d = st_run;
			cnt_d = 16'h0;
			pd_d = 1'b0;
			idl_d = 1'b0;
			gf_d = GF_RESET;
			cfg_d = CFG_RESET;
			src_d = 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock gates and pin conditions follow the next mode
	always_comb
	begin
		cpu_clk_en_d = 1'b1;
		periph_clk_en_d = 1'b1;
		osc_enable_d = 1'b1;
		core_reset_d = 1'b0;
		ram_block_d = 1'b0;
		port_out_d = port_data_in;
		port0_oe_d = core_port0_oe;
		ale_d = core_ale;
		fetch_n_d = core_fetch_strobe_n;
		case (state_d)
			st_run:
			begin
			end
			st_idle:
			begin
				cpu_clk_en_d = 1'b0;
				port_out_d = port_out_q;
				port0_oe_d = !ext_code;
				ale_d = 1'b1;
				fetch_n_d = 1'b1;
			end
			st_pd, st_osc_wait, st_wait_release:
			begin
				// Oscillator stays off until a wake arrives
				cpu_clk_en_d = 1'b0;
				periph_clk_en_d = 1'b0;
				osc_enable_d = (state_d != st_pd);
				port_out_d = port_out_q;
				port0_oe_d = !ext_code;
				ale_d = 1'b0;
				fetch_n_d = 1'b0;
			end
			st_reset_run:
			begin
				// Ports still follow the core; RAM is fenced off
				ram_block_d = 1'b1;
			end
			st_reset_hold:
			begin
				core_reset_d = 1'b1;
				port_out_d = {{(NUM_PORTS-1){PORT_HIGH}}, port_out_q[PORT_W-1:0]};
				port0_oe_d = 1'b0;
				ale_d = 1'b1;
				fetch_n_d = 1'b1;
			end
			default:
			begin
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		state_q <= state_d;
		cnt_q <= cnt_d;
		gf_q <= gf_d;
		cfg_q <= cfg_d;
		src_q <= src_d;
		core_reset_q <= core_reset_d;
		ram_block_q <= ram_block_d;
		port_out_q <= port_out_d;
		port0_oe_q <= port0_oe_d;
		ale_q <= ale_d;
		fetch_n_q <= fetch_n_d;
	end

	// Reset pin acts without a clock: the oscillator may be stopped
	always_ff @(posedge clk or posedge rst_pin)
	begin
		if (rst_pin)
		begin
			idl_q <= 1'b0;
			pd_q <= 1'b0;
			cpu_clk_en_q <= 1'b1;
			periph_clk_en_q <= 1'b1;
			osc_enable_q <= 1'b1;
		end
		else
		begin
			idl_q <= idl_d;
			pd_q <= pd_d;
			cpu_clk_en_q <= cpu_clk_en_d;
			periph_clk_en_q <= periph_clk_en_d;
			osc_enable_q <= osc_enable_d;
		end
	end

	assign avs_readdata = readdata_q;
	assign avs_waitrequest = waitrequest_q;
	assign cpu_clk_en = cpu_clk_en_q;
	assign periph_clk_en = periph_clk_en_q;
	assign osc_enable = osc_enable_q;
	assign core_reset = core_reset_q;
	assign ram_block = ram_block_q;
	assign port_out = port_out_q;
	assign port0_oe = port0_oe_q;
	assign ale = ale_q;
	assign program_fetch_strobe_n = fetch_n_q;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || rst_pin);

	AST_PD_STOPS_CLOCKS: assert property (
		state_q == st_run && !rst_s && power_control_register_wr && avs_writedata[PD_BIT]
		|=> !cpu_clk_en_q && !periph_clk_en_q && !osc_enable_q && pd_q)
		else $error("power-down did not stop clocks on the next edge");

	AST_PD_PRECEDENCE: assert property (
		state_q == st_run && !rst_s && power_control_register_wr && avs_writedata[PD_BIT] && avs_writedata[IDL_BIT]
		|=> state_q == st_pd && !idl_q)
		else $error("idle not dropped when power-down requested with it");

	AST_IDLE_GATES_CPU: assert property (
		state_q == st_run && !rst_s && power_control_register_wr && !avs_writedata[PD_BIT] && avs_writedata[IDL_BIT]
		|=> !cpu_clk_en_q && periph_clk_en_q && osc_enable_q)
		else $error("idle entry gated the wrong clocks");

	AST_ONLY_EXT_WAKE: assert property (
		state_q == st_pd && !wake_req && !rst_s |=> state_q == st_pd && pd_q)
		else $error("power-down left without an enabled external wake");

	AST_WAKE_CLEARS_PD: assert property (
		state_q == st_pd && wake_req && !rst_s |=> !pd_q && osc_enable_q && !cpu_clk_en_q)
		else $error("external wake did not clear power-down and start oscillator");

	AST_OSC_WAIT_MIN: assert property (
		state_q == st_pd && wake_req && !rst_s |=> (!cpu_clk_en_q && state_q == st_osc_wait) [*8])
		else $error("clocks released before oscillator wait");

	AST_RESUME_ON_RELEASE: assert property (
		state_q == st_wait_release && !rst_s |=> (cpu_clk_en_q == !$past(wake_req)))
		else $error("resume not tied to wake line release");

	AST_PD_STROBES_LOW: assert property (
		state_q == st_pd |-> !ale_q && !fetch_n_q)
		else $error("strobes not low in power-down");

	// Reset pin is high for most of this window, so only the system reset disables it
	AST_RESET_PINS: assert property (
		disable iff (reset)
		state_q == st_reset_hold |-> !port0_oe_q && port_out_q[PW-1:PORT_W] == {(NUM_PORTS-1){PORT_HIGH}}
		&& ale_q && fetch_n_q && core_reset_q)
		else $error("pin levels wrong during reset");

	AST_IRQ_CLEARS_IDLE: assert property (
		state_q == st_idle && core_irq_taken && !rst_s |=> !idl_q && cpu_clk_en_q)
		else $error("interrupt did not clear idle request");

	AST_RESET_RUN_LEN: assert property (
		disable iff (reset)
		state_q != st_reset_run ##1 state_q == st_reset_run |-> ram_block_q [*4] ##1 core_reset_q)
		else $error("brief execution window has wrong length");

	AST_INT_WAKE_KEEPS_REGS: assert property (
		state_q == st_pd && wake_req && !rst_s && !power_control_register_wr && !cfg_wr
		|=> !core_reset_q && gf_q == $past(gf_q) && cfg_q == $past(cfg_q))
		else $error("external wake disturbed registers");

	COV_PD_WAKE: cover property (state_q == st_wait_release ##1 state_q == st_run);
	COV_IDLE_IRQ: cover property (state_q == st_idle ##1 state_q == st_run);
	COV_IDLE_RESET: cover property (state_q == st_idle ##1 state_q == st_reset_run);
	COV_PD_RESET: cover property (state_q == st_pd ##1 state_q == st_reset_run);

endmodule : low_power_mode_sequencer

/* wake_pin_model.sv */
// Far-side model: the two external wake lines and the device reset pin.
// Assumes the sequencer synchronises these levels itself; lines idle high.
`timescale 1ns/1ns
module wake_pin_model #(
	parameter int unsigned OSC = 10
) (
	// Clock
	input wire logic clk,
	// Pins
	output logic ext_wake_irq0_n,
	output logic ext_wake_irq1_n,
	output logic rst_pin
);
	initial
	begin
		ext_wake_irq0_n = 1'b1;
		ext_wake_irq1_n = 1'b1;
		rst_pin = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Never shorter than the oscillator settle span, so the release falls after the oscillator wait
	task automatic hold_wake(input int line, input int cycles);
		int n;
		n = (cycles < OSC + 3) ? OSC + 3 : cycles;
		@(posedge clk);
		if (line == 0)
			ext_wake_irq0_n <= 1'b0;
		else
			ext_wake_irq1_n <= 1'b0;
		repeat (n) @(posedge clk);
		ext_wake_irq0_n <= 1'b1;
		ext_wake_irq1_n <= 1'b1;
	endtask : hold_wake

	task automatic drive_reset(input logic level);
		@(posedge clk);
		rst_pin <= level;
	endtask : drive_reset
endmodule : wake_pin_model

/* testbench.sv */
// Self-checking bench for the low-power mode sequencer.
// Assumes the sequencer's Avalon-MM map and a shortened oscillator wait.
`timescale 1ns/1ns
module testbench;
	import lpm_pkg::*;
	localparam int OSC = 10;
	localparam logic [39:0] PORT_IN = 40'h0403020100;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic core_irq_taken = 1'b0;
	logic cpu_clk_en, periph_clk_en, osc_enable, core_reset, ram_block, port0_oe, ale, program_fetch_strobe_n;
	logic [39:0] port_out;
	logic rst_pin, irq0_n, irq1_n;
	int fail_count = 0;
	int total_checks = 0;

	always #20 clk = ~clk;

	wake_pin_model #(.OSC(OSC)) partner (.clk(clk), .ext_wake_irq0_n(irq0_n), .ext_wake_irq1_n(irq1_n),
		.rst_pin(rst_pin));

	low_power_mode_sequencer #(.OSC_CYCLES(OSC)) dut (.clk(clk), .reset(reset), .rst_pin(rst_pin),
		.ext_wake_irq0_n(irq0_n), .ext_wake_irq1_n(irq1_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_irq_taken(core_irq_taken),
		.port_data_in(PORT_IN), .core_port0_oe(1'b1), .core_ale(1'b0), .core_fetch_strobe_n(1'b0),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
		.core_reset(core_reset), .ram_block(ram_block), .port_out(port_out), .port0_oe(port0_oe),
		.ale(ale), .program_fetch_strobe_n(program_fetch_strobe_n));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd,
		input logic [3:0] be = 4'hf);
		int n;
		n = 0;
		@(posedge clk);
		avs_byteenable <= be;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		chk(n < 50, "bus answer missing");
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic pulse_irq_taken();
		@(posedge clk);
		core_irq_taken <= 1'b1;
		@(posedge clk);
		core_irq_taken <= 1'b0;
	endtask : pulse_irq_taken

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////
	task automatic test_reset_values();
		logic [31:0] r;
		bus(1'b0, POWER_CONTROL_REGISTER_OFF, 32'h0, r);
		chk(r[3:0] === 4'h0, "control reset value");
		// Lane 0 disabled: the write must be ignored
		bus(1'b1, CFG_OFF, 32'h7, r, 4'he);
		bus(1'b0, CFG_OFF, 32'h0, r);
		chk(r[2:0] === 3'h0, "config reset value");
		bus(1'b0, STAT_OFF, 32'h0, r);
		chk(r[7:0] === 8'h08, "status after reset");
		bus(1'b0, 4'hc, 32'h0, r);
		chk(r === 32'h0, "unmapped read");
		$display("test reset_values done");
	endtask : test_reset_values

	task automatic test_idle();
		logic [31:0] r;
		bus(1'b1, POWER_CONTROL_REGISTER_OFF, 32'h1, r);
		repeat (2) @(posedge clk);
		#1;
		chk(cpu_clk_en === 1'b0 && periph_clk_en === 1'b1 && osc_enable === 1'b1, "idle gating");
		chk(ale === 1'b1 && program_fetch_strobe_n === 1'b1 && port0_oe === 1'b1, "idle strobes");
		chk(port_out === PORT_IN, "idle port data");
		bus(1'b0, STAT_OFF, 32'h0, r);
		chk(r[2:0] === 3'h1, "idle mode status");
		pulse_irq_taken();
		@(posedge clk);
		#1;
		chk(cpu_clk_en === 1'b1, "idle exit by interrupt");
		bus(1'b0, POWER_CONTROL_REGISTER_OFF, 32'h0, r);
		chk(r[1:0] === 2'h0, "idle bit cleared");
		$display("test idle done");
	endtask : test_idle

	task automatic test_pd_wake();
		logic [31:0] r;
		bus(1'b1, CFG_OFF, 32'h5, r);
		bus(1'b1, POWER_CONTROL_REGISTER_OFF, 32'hf, r);
		repeat (2) @(posedge clk);
		#1;
		chk(cpu_clk_en === 1'b0 && periph_clk_en === 1'b0 && osc_enable === 1'b0, "pd clocks");
		chk(ale === 1'b0 && program_fetch_strobe_n === 1'b0 && port0_oe === 1'b0, "pd pins");
		chk(port_out[39:8] === PORT_IN[39:8], "pd port data");
		bus(1'b0, STAT_OFF, 32'h0, r);
		chk(r[2:0] === 3'h2, "pd over idle");
		pulse_irq_taken();
		partner.hold_wake(1, OSC + 3);
		repeat (4) @(posedge clk);
		#1;
		chk(osc_enable === 1'b0 && cpu_clk_en === 1'b0, "disabled source woke");
		fork
			partner.hold_wake(0, OSC + 8);
			begin
				repeat (6) @(posedge clk);
				#1;
				chk(osc_enable === 1'b1 && cpu_clk_en === 1'b0, "osc restart, cpu held");
				repeat (OSC + 2) @(posedge clk);
				#1;
				chk(cpu_clk_en === 1'b0 && periph_clk_en === 1'b0, "clocks before release");
			end
		join
		repeat (4) @(posedge clk);
		#1;
		chk(cpu_clk_en === 1'b1 && periph_clk_en === 1'b1, "clocks after release");
		bus(1'b0, POWER_CONTROL_REGISTER_OFF, 32'h0, r);
		chk(r[3:0] === 4'hc, "flags kept, requests clear");
		$display("test pd_wake done");
	endtask : test_pd_wake

	task automatic test_reset_wake(input logic [31:0] power_control_register_val);
		logic [31:0] r;
		logic seen;
		int n;
		seen = 1'b0;
		n = 0;
		bus(1'b1, CFG_OFF, 32'h3, r);
		bus(1'b1, POWER_CONTROL_REGISTER_OFF, power_control_register_val, r);
		repeat (2) @(posedge clk);
		partner.drive_reset(1'b1);
		#5;
		chk(cpu_clk_en === 1'b1 && osc_enable === 1'b1, "async clock restore");
		while (core_reset !== 1'b1 && n < 30)
		begin
			@(posedge clk);
			#1;
			if (ram_block === 1'b1)
				seen = 1'b1;
			n++;
		end
		chk(seen === 1'b1 && core_reset === 1'b1, "brief run then reset");
		chk(port0_oe === 1'b0 && port_out[39:8] === 32'hffffffff, "reset ports");
		chk(ale === 1'b1 && program_fetch_strobe_n === 1'b1, "reset strobes");
		partner.drive_reset(1'b0);
		n = 0;
		while (core_reset !== 1'b0 && n < 30)
		begin
			@(posedge clk);
			n++;
		end
		bus(1'b0, POWER_CONTROL_REGISTER_OFF, 32'h0, r);
		chk(r[3:0] === 4'h0, "control cleared by reset");
		bus(1'b0, CFG_OFF, 32'h0, r);
		chk(r[2:0] === 3'h0, "config cleared by reset");
		$display("test reset_wake %0h done", power_control_register_val);
	endtask : test_reset_wake

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		test_reset_values();
		test_idle();
		test_pd_wake();
		test_reset_wake(32'hd);
		test_reset_wake(32'he);
		report_and_stop();
	end

	// Whole run is under two hundred cycles; this span only cuts a hang
	initial
	begin
		repeat (3000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule : testbench
